// ---- design/mms_memmap.sv ----
// mms_memmap: memory-map decode, vectors and access protection
// assumes: core ports, host port and memories run on clk_in; the
// rom mode pin is asynchronous; memories answer in the request cycle
`timescale 1ns/1ps
module mms_memmap #(
  parameter mms_pkg::mms_sec_e SEC_LEVEL = mms_pkg::SEC_NONE,
  parameter mms_pkg::mms_hpol_e HP_POLICY = mms_pkg::HP_OPEN,
  parameter bit SHARED_EN = 1'b0,
  parameter int PAGE_W = 7
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire logic rom_mode_pin_in,
  input wire logic page_load_in,
  input wire logic [PAGE_W-1:0] page_val_in,
  input wire logic trap_in,
  input wire logic [4:0] trap_num_in,
  output logic pc_load_out,
  output logic [15:0] pc_vector_out,
  input wire logic p_req_in,
  input wire logic p_fetch_in,
  input wire logic [15:0] p_addr_in,
  input wire logic [15:0] p_rdata_in,
  output mms_pkg::mms_region_e p_region_out,
  output logic p_ext_req_out,
  output logic [PAGE_W+15:0] p_ext_addr_out,
  output logic [15:0] p_rdata_out,
  input wire logic da_req_in,
  input wire logic [15:0] da_addr_in,
  input wire logic [15:0] da_rdata_in,
  output mms_pkg::mms_region_e da_region_out,
  output logic da_ext_req_out,
  output logic [15:0] da_rdata_out,
  input wire logic db_req_in,
  input wire logic [15:0] db_addr_in,
  input wire logic [15:0] db_rdata_in,
  output mms_pkg::mms_region_e db_region_out,
  output logic db_ext_req_out,
  output logic [15:0] db_rdata_out,
  input wire logic c2_req_in,
  output logic c2_sh_en_out,
  input wire logic hp_wr_in,
  input wire logic hp_rd_in,
  input wire logic [15:0] hp_addr_in,
  input wire logic [15:0] hp_rdata_in,
  output logic hp_we_out,
  output logic [15:0] hp_rdata_out,
  output logic rom_mode_out,
  output logic emu_en_out,
  output logic bscan_en_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_SYNC = 2'h0,
    ST_BOOT = 2'h1,
    ST_RUN  = 2'h2
  } mms_phase_e;

  typedef struct packed {
    mms_phase_e phase;
    logic [1:0] sync_cnt;
    logic pin_s1;
    logic pin_s2;
    logic mode_pin;
    logic ram_overlay_bit;
    logic rom_data_map_bit;
    logic [8:0] vector_page_pointer;
    logic [PAGE_W-1:0] program_page_extension;
    mms_pkg::mms_region_e origin;
    logic [15:0] rdata;
    logic pc_load;
    logic [15:0] pc_vec;
  } mms_state_s;

  mms_state_s st_reg;
  mms_state_s st_next;

  // count equal to the two stages, so stage two already holds the pin
  localparam logic [1:0] SYNC_LAST = 2'(mms_pkg::SYNC_CYCLES);

  // ----------------------------------------------------------------
  // mode and security decisions
  // ----------------------------------------------------------------
  logic rom_on;
  logic rom_mode_sel;
  logic page_zero;
  logic [15:0] processor_mode_reg;
  mms_pkg::mms_region_e p_region;
  mms_pkg::mms_region_e da_region;
  mms_pkg::mms_region_e db_region;
  mms_pkg::mms_region_e hp_region;
  logic p_mask;
  logic da_mask;
  logic db_mask;
  logic hp_mask;
  logic hp_in_win;

  assign rom_mode_sel = (SEC_LEVEL == mms_pkg::SEC_ROMRAM) ?
                        1'b0 : st_reg.mode_pin;
  // low select means rom present in program space
  assign rom_on = ~rom_mode_sel;
  assign page_zero = (st_reg.program_page_extension == '0);

  // mode register image: pointer, live mode, overlay, rom-to-data
  always_comb
  begin
    processor_mode_reg = 16'h0000;
    processor_mode_reg[15:mms_pkg::VPP_LSB] = st_reg.vector_page_pointer;
    processor_mode_reg[mms_pkg::BIT_ROMSEL] = rom_mode_sel;
    processor_mode_reg[mms_pkg::BIT_ROMD] = st_reg.rom_data_map_bit;
    processor_mode_reg[mms_pkg::BIT_OVL] = st_reg.ram_overlay_bit;
  end

  // ----------------------------------------------------------------
  // region decoders, one per independent port
  // ----------------------------------------------------------------
  // program address decode
  mms_region_dec #(.SHARED_EN(SHARED_EN)) u_dec_p (
    .addr_in(p_addr_in),
    .is_prog_in(1'b1),
    .page_zero_in(page_zero),
    .ovl_in(st_reg.ram_overlay_bit),
    .romd_in(st_reg.rom_data_map_bit),
    .rom_on_in(rom_on),
    .region_out(p_region)
  );

  mms_region_dec #(.SHARED_EN(SHARED_EN)) u_dec_a (
    .addr_in(da_addr_in),
    .is_prog_in(1'b0),
    .page_zero_in(1'b1),
    .ovl_in(st_reg.ram_overlay_bit),
    .romd_in(st_reg.rom_data_map_bit),
    .rom_on_in(rom_on),
    .region_out(da_region)
  );

  mms_region_dec #(.SHARED_EN(SHARED_EN)) u_dec_b (
    .addr_in(db_addr_in),
    .is_prog_in(1'b0),
    .page_zero_in(1'b1),
    .ovl_in(st_reg.ram_overlay_bit),
    .romd_in(st_reg.rom_data_map_bit),
    .rom_on_in(rom_on),
    .region_out(db_region)
  );

  // host sees the data map
  mms_region_dec #(.SHARED_EN(SHARED_EN)) u_dec_h (
    .addr_in(hp_addr_in),
    .is_prog_in(1'b0),
    .page_zero_in(1'b1),
    .ovl_in(st_reg.ram_overlay_bit),
    .romd_in(st_reg.rom_data_map_bit),
    .rom_on_in(rom_on),
    .region_out(hp_region)
  );

  // checks use fetch origin
  // a fetch itself is never masked: the core must run its own code
  assign p_mask = ~p_fetch_in &&
                  mms_pkg::sec_mask(SEC_LEVEL, st_reg.origin, p_region);
  assign da_mask = mms_pkg::sec_mask(SEC_LEVEL, st_reg.origin,
                                     da_region);
  assign db_mask = mms_pkg::sec_mask(SEC_LEVEL, st_reg.origin,
                                     db_region);

  assign hp_in_win = (hp_addr_in >= mms_pkg::HP_WIN_LO) &&
                     (hp_addr_in <= mms_pkg::HP_WIN_HI);
  always_comb
  begin
    hp_mask = 1'b0;
    if (SEC_LEVEL != mms_pkg::SEC_NONE)
    begin
      case (HP_POLICY)
        mms_pkg::HP_BLOCK: hp_mask = 1'b1;
        mms_pkg::HP_WINDOW: hp_mask = ~hp_in_win;
        default: hp_mask = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.pc_load = 1'b0;
    st_next.rdata = 16'h0000;
    // mode pin synchroniser, second stage only is read further on
    st_next.pin_s1 = rom_mode_pin_in;
    st_next.pin_s2 = st_reg.pin_s1;

    case (st_reg.phase)
      ST_SYNC:
      begin
        st_next.sync_cnt = st_reg.sync_cnt + 2'h1;
        if (st_reg.sync_cnt == SYNC_LAST)
        begin
          st_next.mode_pin = st_reg.pin_s2;
          st_next.phase = ST_BOOT;
        end
      end
      ST_BOOT:
      begin
        st_next.pc_load = 1'b1;
        st_next.pc_vec = mms_pkg::RESET_VEC;
        st_next.origin = mms_pkg::RG_EXT;
        st_next.phase = ST_RUN;
      end
      ST_RUN:
      begin
        if (trap_in)
        begin
          st_next.pc_load = 1'b1;
          st_next.pc_vec = {st_reg.vector_page_pointer, 7'h00} |
            16'({trap_num_in, {mms_pkg::VEC_WORDS_LOG2{1'b0}}});
        end
      end
      default: st_next.phase = ST_SYNC;
    endcase

    if (p_req_in && p_fetch_in)
      st_next.origin = p_region;

    // register writes; no security write path
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        mms_pkg::OFS_MODE:
        begin
          st_next.vector_page_pointer =
            reg_wdata_in[15:mms_pkg::VPP_LSB];
          st_next.ram_overlay_bit = reg_wdata_in[mms_pkg::BIT_OVL];
          st_next.rom_data_map_bit = reg_wdata_in[mms_pkg::BIT_ROMD];
        end
        mms_pkg::OFS_PAGE:
          st_next.program_page_extension = reg_wdata_in[PAGE_W-1:0];
        default: st_next.rdata = st_next.rdata;
      endcase
    end
    // far transfers load page; core wins over software
    if (page_load_in)
      st_next.program_page_extension = page_val_in;

    // read data for the cycle after the strobe
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        mms_pkg::OFS_MODE: st_next.rdata = processor_mode_reg;
        mms_pkg::OFS_PAGE:
          st_next.rdata = 16'(st_reg.program_page_extension);
        mms_pkg::OFS_SEC:
          st_next.rdata = {12'h000, HP_POLICY, SEC_LEVEL};
        default: st_next.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset takes constants only; the pin is caught later in ST_SYNC
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st_reg <= '0;
      st_reg.phase <= ST_SYNC;
      st_reg.vector_page_pointer <= mms_pkg::VPP_RST;
      st_reg.program_page_extension <= PAGE_W'(mms_pkg::PAGE_RST);
      st_reg.origin <= mms_pkg::RG_EXT;
    end
    else if (clk_en_in)
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // read returns through the guards
  // ----------------------------------------------------------------
  // rom masking, plus on-chip ram masking under rom/ram security
  mms_rd_guard #(.W(16)) u_grd_p (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .take_in(p_req_in),
    .mask_in(p_mask),
    .data_in(p_rdata_in),
    .data_out(p_rdata_out)
  );

  mms_rd_guard #(.W(16)) u_grd_a (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .take_in(da_req_in),
    .mask_in(da_mask),
    .data_in(da_rdata_in),
    .data_out(da_rdata_out)
  );

  mms_rd_guard #(.W(16)) u_grd_b (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .take_in(db_req_in),
    .mask_in(db_mask),
    .data_in(db_rdata_in),
    .data_out(db_rdata_out)
  );

  // refused host reads of on-chip memory return the invalid word
  mms_rd_guard #(.W(16)) u_grd_h (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .take_in(hp_rd_in),
    .mask_in(hp_mask && (hp_region != mms_pkg::RG_EXT)),
    .data_in(hp_rdata_in),
    .data_out(hp_rdata_out)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // page register above every program address
  assign p_ext_addr_out = {st_reg.program_page_extension, p_addr_in};
  assign p_region_out = p_region;
  assign p_ext_req_out = p_req_in && (p_region == mms_pkg::RG_EXT);
  assign da_region_out = da_region;
  assign da_ext_req_out = da_req_in && (da_region == mms_pkg::RG_EXT);
  assign db_region_out = db_region;
  assign db_ext_req_out = db_req_in && (db_region == mms_pkg::RG_EXT);
  assign c2_sh_en_out = c2_req_in && SHARED_EN;
  assign hp_we_out = hp_wr_in;
  assign rom_mode_out = rom_mode_sel;
  assign emu_en_out = (SEC_LEVEL == mms_pkg::SEC_NONE);
  assign bscan_en_out = 1'b1;
  assign pc_load_out = st_reg.pc_load;
  assign pc_vector_out = st_reg.pc_vec;
  assign reg_rdata_out = st_reg.rdata;

endmodule

// ---- design/mms_pkg.sv ----
// mms_pkg: constants, types and access checks of the memory-map block
// assumes: compiled ahead of every mms module; nothing is imported
package mms_pkg;

  // ----------------------------------------------------------------
  // region, security and host-read policy codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RG_EXT   = 3'h0,
    RG_DUAL = 3'h1,
    RG_SINGLE = 3'h2,
    RG_ROM   = 3'h3,
    RG_SHRAM = 3'h4
  } mms_region_e;

  typedef enum logic [1:0] {
    SEC_NONE   = 2'h0,
    SEC_ROM    = 2'h1,
    SEC_ROMRAM = 2'h2
  } mms_sec_e;

  typedef enum logic [1:0] {
    HP_OPEN   = 2'h0,
    HP_BLOCK  = 2'h1,
    HP_WINDOW = 2'h2
  } mms_hpol_e;

  // ----------------------------------------------------------------
  // register offsets, field positions, reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_PAGE = 4'h1;
  localparam logic [3:0] OFS_SEC = 4'h2;
  localparam int BIT_OVL = 0;
  localparam int BIT_ROMD = 1;
  localparam int BIT_ROMSEL = 2;
  localparam int VPP_LSB = 7;
  localparam logic [8:0] VPP_RST = 9'h1ff;
  localparam logic [6:0] PAGE_RST = 7'h00;

  // ----------------------------------------------------------------
  // map bounds, vectors, fixed values
  // ----------------------------------------------------------------
  localparam logic [15:0] DUAL_LO = 16'h0080;
  localparam logic [15:0] DUAL_HI = 16'h27ff;
  localparam logic [15:0] SINGLE_LO = 16'h2800;
  localparam logic [15:0] SINGLE_HI = 16'h7fff;
  localparam logic [15:0] SHRAM_LO = 16'h8000;
  localparam logic [15:0] SHRAM_HI = 16'hbfff;
  localparam logic [15:0] ROM_LO = 16'hc000;
  localparam logic [15:0] HP_WIN_LO = 16'h1000;
  localparam logic [15:0] HP_WIN_HI = 16'h17ff;
  localparam logic [15:0] RESET_VEC = 16'hff80;
  localparam logic [15:0] BAD_DATA = 16'hffff;
  localparam int VEC_WORDS_LOG2 = 2;
  localparam int VPAGE_LOG2 = 7;
  localparam int SYNC_CYCLES = 2;

  // on-chip RAM of any kind
  function automatic logic is_ram(input mms_region_e r);
    is_ram = (r == RG_DUAL) || (r == RG_SINGLE) || (r == RG_SHRAM);
  endfunction

  // read of target by an instruction fetched from origin is masked
  function automatic logic sec_mask(input mms_sec_e lvl,
                                    input mms_region_e origin,
                                    input mms_region_e target);
    logic onchip;
    onchip = (target == RG_ROM) || is_ram(target);
    case (lvl)
      SEC_ROM: sec_mask = (target == RG_ROM) && (origin != RG_ROM);
      SEC_ROMRAM: sec_mask = onchip && (origin == RG_EXT);
      default: sec_mask = 1'b0;
    endcase
  endfunction

endpackage

// ---- design/mms_region_dec.sv ----
// mms_region_dec: places one 16-bit address in a region of the map
// assumes: control bits come from flops of the same clock
`timescale 1ns/1ps
module mms_region_dec #(
  parameter bit SHARED_EN = 1'b0
) (
  input wire logic [15:0] addr_in,
  input wire logic is_prog_in,
  input wire logic page_zero_in,
  input wire logic ovl_in,
  input wire logic romd_in,
  input wire logic rom_on_in,
  output mms_pkg::mms_region_e region_out
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic in_da;
  logic in_sa;
  logic in_sh;
  logic in_rom;

  assign in_da = (addr_in >= mms_pkg::DUAL_LO) &&
                 (addr_in <= mms_pkg::DUAL_HI);
  assign in_sa = (addr_in >= mms_pkg::SINGLE_LO) &&
                 (addr_in <= mms_pkg::SINGLE_HI);
  assign in_sh = (addr_in >= mms_pkg::SHRAM_LO) &&
                 (addr_in <= mms_pkg::SHRAM_HI);
  assign in_rom = (addr_in >= mms_pkg::ROM_LO);

  // program side: dual/single RAM only with overlay, on every page; shared RAM and rom page 0
  always_comb
  begin
    region_out = mms_pkg::RG_EXT;
    if (is_prog_in)
    begin
      if (ovl_in && in_da)
        region_out = mms_pkg::RG_DUAL;
      else if (ovl_in && in_sa)
        region_out = mms_pkg::RG_SINGLE;
      else if (SHARED_EN && page_zero_in && in_sh)
        region_out = mms_pkg::RG_SHRAM;
      else if (rom_on_in && page_zero_in && in_rom)
        region_out = mms_pkg::RG_ROM;
    end
    else
    begin
      if (in_da)
        region_out = mms_pkg::RG_DUAL;
      else if (in_sa)
        region_out = mms_pkg::RG_SINGLE;
      else if (romd_in && in_rom)
        region_out = mms_pkg::RG_ROM;
    end
  end

endmodule

// ---- design/mms_rd_guard.sv ----
// mms_rd_guard: registers one read return, substituting the
// invalid-data word when the access is refused
// assumes: memory read data is valid in the cycle of the request
`timescale 1ns/1ps
module mms_rd_guard #(
  parameter int W = 16
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic take_in,
  input wire logic mask_in,
  input wire logic [W-1:0] data_in,
  output logic [W-1:0] data_out
);

  typedef struct packed {
    logic [W-1:0] data;
  } mms_guard_s;

  mms_guard_s st_reg;
  mms_guard_s st_next;

  // ----------------------------------------------------------------
  // next state: hold between reads
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    if (take_in)
      st_next.data = mask_in ? W'(mms_pkg::BAD_DATA) : data_in;
  end

  // state register
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      st_reg <= '0;
    else if (clk_en_in)
      st_reg <= st_next;
  end

  assign data_out = st_reg.data;

endmodule

// ---- test/mms_far_mem.sv ----
// mms_far_mem: one far-side memory port answering in the same cycle
// assumes: the bench gives each port its own salt
`timescale 1ns/1ps
module mms_far_mem #(
  parameter logic [15:0] SALT = 16'h0000
) (
  input wire logic req_in,
  input wire logic [15:0] addr_in,
  output logic [15:0] word_out
);
  // idle bus shows junk, so stale data never passes as a read
  assign word_out = req_in ? (addr_in ^ SALT) : ~(addr_in ^ SALT);
endmodule

// ---- test/mms_memmap_props.sv ----
// mms_memmap_props: timing relations at the memory-map ports
// assumes: one clock, clk_en_in held high by the bench
`timescale 1ns/1ps
module mms_memmap_chk #(
  parameter mms_pkg::mms_sec_e SEC_LEVEL = mms_pkg::SEC_NONE,
  parameter mms_pkg::mms_hpol_e HP_POLICY = mms_pkg::HP_OPEN,
  parameter bit SHARED_EN = 1'b0,
  parameter int PAGE_W = 7
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic p_req_in,
  input wire logic p_fetch_in,
  input wire logic [15:0] p_addr_in,
  input wire logic [15:0] p_rdata_in,
  input wire mms_pkg::mms_region_e p_region_out,
  input wire logic p_ext_req_out,
  input wire logic [PAGE_W+15:0] p_ext_addr_out,
  input wire logic [15:0] p_rdata_out,
  input wire logic da_req_in,
  input wire logic [15:0] da_rdata_in,
  input wire mms_pkg::mms_region_e da_region_out,
  input wire logic [15:0] da_rdata_out,
  input wire logic pc_load_out,
  input wire logic [15:0] pc_vector_out,
  input wire logic c2_req_in,
  input wire logic c2_sh_en_out,
  input wire logic hp_wr_in,
  input wire logic hp_rd_in,
  input wire logic [15:0] hp_addr_in,
  input wire logic [15:0] hp_rdata_in,
  input wire logic hp_we_out,
  input wire logic [15:0] hp_rdata_out,
  input wire logic rom_mode_out,
  input wire logic emu_en_out,
  input wire logic bscan_en_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // ----------------------------------------------------------------
  // decode and return paths
  // ----------------------------------------------------------------
  AST_P_EXT: assert property (p_ext_req_out ==
    (p_req_in && p_region_out == mms_pkg::RG_EXT)) else $error("ext req");
  AST_EXT_ADDR: assert property (p_req_in |->
    p_ext_addr_out[15:0] == p_addr_in) else $error("ext addr");
  AST_DATA_EXT: assert property (da_req_in &&
    da_region_out == mms_pkg::RG_EXT |=> da_rdata_out == $past(da_rdata_in))
    else $error("ext data return");
  AST_FETCH: assert property (p_req_in && p_fetch_in |=>
    p_rdata_out == $past(p_rdata_in)) else $error("fetch masked");
  // ----------------------------------------------------------------
  // vectors, security, host port
  // ----------------------------------------------------------------
  AST_PC_PULSE: assert property (pc_load_out |=> !pc_load_out)
    else $error("pc load too long");
  AST_VEC: assert property (pc_load_out |->
    pc_vector_out[1:0] == 2'h0) else $error("vector not 4-word");
  AST_ROMRAM: assert property (SEC_LEVEL == mms_pkg::SEC_ROMRAM
    |-> !rom_mode_out) else $error("rom mode not forced");
  AST_EMU: assert property (emu_en_out ==
    (SEC_LEVEL == mms_pkg::SEC_NONE) && bscan_en_out) else $error("emu");
  AST_C2: assert property (c2_sh_en_out ==
    (c2_req_in && SHARED_EN)) else $error("shared ram grant");
  AST_HP_WE: assert property (hp_we_out == hp_wr_in)
    else $error("host write");
  AST_HP_WIN: assert property (hp_rd_in &&
    HP_POLICY == mms_pkg::HP_WINDOW && hp_addr_in >= mms_pkg::HP_WIN_LO &&
    hp_addr_in <= mms_pkg::HP_WIN_HI |=> hp_rdata_out == $past(hp_rdata_in))
    else $error("host window read");
endmodule

bind mms_memmap mms_memmap_chk #(.SEC_LEVEL(SEC_LEVEL),
  .HP_POLICY(HP_POLICY), .SHARED_EN(SHARED_EN), .PAGE_W(PAGE_W))
  i_mms_memmap_chk (.*);

// ---- test/mms_memmap_tb.sv ----
// mms_memmap_tb: scenario bench for the memory-map block
// assumes: rom/ram security, host window policy, shared ram present
`timescale 1ns/1ps
module mms_memmap_tb;
  localparam logic [15:0] PS = 16'h1100;
  localparam logic [15:0] DS = 16'h2200;
  localparam logic [15:0] BS = 16'h3300;
  localparam logic [15:0] HS = 16'h4400;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_q, pc_vec, p_d, p_q, da_d, da_q;
  logic [15:0] db_d, db_q, hp_d, hp_q;
  logic da_ext, db_ext;
  logic [15:0] p_addr = '0, da_addr = '0, db_addr = '0, hp_addr = '0;
  logic reg_wr = 0, reg_rd = 0, pg_ld = 0, trap = 0, p_req = 0;
  logic p_fetch = 0, da_req = 0, db_req = 0, c2_req = 0, hp_wr = 0;
  logic hp_rd = 0, pc_ld, p_ext, c2_en, hp_we, rom_mode, emu, bscan;
  logic [6:0] pg_val = '0, cur_pg = '0;
  logic [4:0] tnum = '0;
  logic [22:0] p_xa;
  mms_pkg::mms_region_e p_rg, da_rg, db_rg;
  int n_fail = 0;
  int check_count = 0;

  // ----------------------------------------------------------------
  // clock, design, far memories
  // ----------------------------------------------------------------
  always #12.5 clk_in = ~clk_in;
  mms_memmap #(.SEC_LEVEL(mms_pkg::SEC_ROMRAM),
    .HP_POLICY(mms_pkg::HP_WINDOW), .SHARED_EN(1'b1)) i_mms_memmap (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_q), .rom_mode_pin_in(1'b1),
    .page_load_in(pg_ld), .page_val_in(pg_val), .trap_in(trap),
    .trap_num_in(tnum), .pc_load_out(pc_ld), .pc_vector_out(pc_vec),
    .p_req_in(p_req), .p_fetch_in(p_fetch), .p_addr_in(p_addr),
    .p_rdata_in(p_d), .p_region_out(p_rg), .p_ext_req_out(p_ext),
    .p_ext_addr_out(p_xa), .p_rdata_out(p_q), .da_req_in(da_req),
    .da_addr_in(da_addr), .da_rdata_in(da_d), .da_region_out(da_rg),
    .da_ext_req_out(da_ext), .da_rdata_out(da_q), .db_req_in(db_req),
    .db_addr_in(db_addr), .db_rdata_in(db_d), .db_region_out(db_rg),
    .db_ext_req_out(db_ext), .db_rdata_out(db_q), .c2_req_in(c2_req),
    .c2_sh_en_out(c2_en), .hp_wr_in(hp_wr), .hp_rd_in(hp_rd),
    .hp_addr_in(hp_addr), .hp_rdata_in(hp_d), .hp_we_out(hp_we),
    .hp_rdata_out(hp_q), .rom_mode_out(rom_mode), .emu_en_out(emu),
    .bscan_en_out(bscan));
  mms_far_mem #(.SALT(PS)) i_far_p (.req_in(p_req), .addr_in(p_addr),
    .word_out(p_d));
  mms_far_mem #(.SALT(DS)) i_far_da (.req_in(da_req), .addr_in(da_addr),
    .word_out(da_d));
  mms_far_mem #(.SALT(BS)) i_far_db (.req_in(db_req), .addr_in(db_addr),
    .word_out(db_d));
  mms_far_mem #(.SALT(HS)) i_far_hp (.req_in(hp_rd), .addr_in(hp_addr),
    .word_out(hp_d));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one register cycle; d is write data or expected read data
  task automatic reg_op(input logic wr, input logic [3:0] a,
                        input logic [15:0] d);
    @(posedge clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk_in);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    if (!wr)
      chk(reg_q, d);
  endtask

  // port 0 program, 1 data a, 2 data b, 3 host read
  task automatic rd(input int pt, input logic f, input logic [15:0] a,
                    input logic [2:0] rg, input logic [15:0] d);
    @(posedge clk_in);
    case (pt)
      0: {p_req, p_fetch, p_addr} <= {1'b1, f, a};
      1: {da_req, da_addr} <= {1'b1, a};
      2: {db_req, db_addr} <= {1'b1, a};
      default: {hp_rd, hp_addr} <= {1'b1, a};
    endcase
    #1;
    case (pt)
      0: chk(p_rg, rg);
      1: chk(da_rg, rg);
      2: chk(db_rg, rg);
      default: chk(hp_we, 1'b0);
    endcase
    chk({p_ext, da_ext, db_ext},
        (pt < 3 && rg == 0) ? 3'h4 >> pt : 3'h0);
    if (pt == 0)
      chk(p_xa[22:16], cur_pg);
    @(posedge clk_in);
    {p_req, da_req, db_req, hp_rd} <= 4'h0;
    #1;
    case (pt)
      0: chk(p_q, d);
      1: chk(da_q, d);
      2: chk(db_q, d);
      default: chk(hp_q, d);
    endcase
  endtask

  task automatic trap_go(input logic [4:0] n, input logic [15:0] v);
    @(posedge clk_in);
    {trap, tnum} <= {1'b1, n};
    @(posedge clk_in);
    trap <= 1'b0;
    #1;
    chk(pc_ld, 1'b1);
    chk(pc_vec, v);
    @(posedge clk_in);
    #1;
    chk(pc_ld, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_boot();
    for (int i = 0; i < 10 && pc_ld !== 1'b1; i++)
    begin
      @(posedge clk_in);
      #1;
    end
    if (pc_ld !== 1'b1)
    begin
      n_fail++;
      final_report();
    end
    chk(pc_vec, 16'hff80);
    chk(rom_mode, 1'b0);
    chk({emu, bscan}, 2'b01);
    reg_op(0, 4'h0, 16'hff80);
    reg_op(0, 4'h2, 16'h000a);
    reg_op(1, 4'h2, 16'h0000);
    reg_op(0, 4'h2, 16'h000a);
    reg_op(1, 4'h0, 16'hff84);
    reg_op(0, 4'h0, 16'hff80);
    reg_op(0, 4'h7, 16'h0000);
  endtask

  // fetch origin starts external, so on-chip reads are masked
  task automatic t_sec();
    rd(1, 0, 16'h0100, 1, 16'hffff);
    rd(3, 0, 16'h1000, 0, 16'h1000 ^ HS);
    rd(3, 0, 16'h2000, 0, 16'hffff);
    rd(0, 0, 16'hc000, 3, 16'hffff);
    rd(1, 0, 16'hc000, 0, 16'hc000 ^ DS);
    rd(0, 1, 16'hc000, 3, 16'hc000 ^ PS);
    rd(1, 0, 16'h0100, 1, 16'h0100 ^ DS);
    rd(2, 0, 16'h3000, 2, 16'h3000 ^ BS);
    rd(0, 0, 16'hc004, 3, 16'hc004 ^ PS);
    rd(0, 1, 16'h1000, 0, 16'h1000 ^ PS);
    rd(2, 0, 16'h3000, 2, 16'hffff);
    rd(1, 0, 16'h8000, 0, 16'h8000 ^ DS);
  endtask

  // both data ports hit dual ram in one cycle
  task automatic t_dual();
    rd(0, 1, 16'hc008, 3, 16'hc008 ^ PS);
    @(posedge clk_in);
    {da_req, da_addr, db_req, db_addr} <= {1'b1, 16'h0100, 1'b1, 16'h0200};
    hp_wr <= 1'b1;
    #1;
    chk(da_rg, mms_pkg::RG_DUAL);
    chk(db_rg, mms_pkg::RG_DUAL);
    chk(hp_we, 1'b1);
    @(posedge clk_in);
    {da_req, db_req, hp_wr} <= 3'b000;
    #1;
    chk(da_q, 16'h0100 ^ DS);
    chk(db_q, 16'h0200 ^ BS);
  endtask

  task automatic t_trap();
    reg_op(1, 4'h0, 16'h0082);
    reg_op(0, 4'h0, 16'h0082);
    trap_go(5'h03, 16'h008c);
    trap_go(5'h1f, 16'h00fc);
    rd(1, 0, 16'hc000, 3, 16'hc000 ^ DS);
  endtask

  task automatic t_page();
    rd(0, 1, 16'h0100, 0, 16'h0100 ^ PS);
    @(posedge clk_in);
    {pg_ld, pg_val} <= {1'b1, 7'h05};
    @(posedge clk_in);
    pg_ld <= 1'b0;
    cur_pg = 7'h05;
    rd(0, 1, 16'h0100, 0, 16'h0100 ^ PS);
    reg_op(1, 4'h0, 16'h0083);
    rd(0, 1, 16'h0100, 1, 16'h0100 ^ PS);
    rd(0, 1, 16'h3000, 2, 16'h3000 ^ PS);
    rd(0, 1, 16'h8000, 0, 16'h8000 ^ PS);
    @(posedge clk_in);
    {pg_ld, pg_val, c2_req} <= {1'b1, 7'h00, 1'b1};
    @(posedge clk_in);
    pg_ld <= 1'b0;
    cur_pg = 7'h00;
    rd(0, 1, 16'h8000, 4, 16'h8000 ^ PS);
    chk(c2_en, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_boot();
    t_sec();
    t_dual();
    t_trap();
    t_page();
    final_report();
  end
endmodule
